//--- hw/rlqm_monitor.sv
`timescale 1ns/1ps
module rlqm_monitor #(
   parameter bit IS_TX = 1'b1,
   parameter int LAT_W = 10
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire rlqm_pkg::rlqm_reg_req_t reg_req,
   output logic [7:0] reg_rdata,
   input wire logic frame_end,
   input wire logic packet_lost,
   input wire logic link_up,
   input wire logic link_init_fail,
   output logic irq_pin,
   output logic audio_mute,
   output logic afh_disable,
   output logic force_reconfig,
   output logic restore_defaults,
   output logic [LAT_W-1:0] latency_samples
);

   // ---------------------------------------------------------------
   // Registers and decode
   // ---------------------------------------------------------------
   logic [7:0] mode_reg;
   logic [7:0] warn_reg;
   logic [7:0] alarm_reg;
   logic [7:0] latency_reg;
   logic [7:0] irq_cfg_reg;
   logic poor_flag_reg;
   logic err_flag_reg;
   logic [7:0] flags_view;
   logic [7:0] quality_reg;
   logic [7:0] errors_reg;
   logic link_reg;
   logic [3:0] qframe_reg;
   logic [4:0] eframe_reg;
   logic [7:0] qlost_reg;
   logic [7:0] elost_reg;
   logic [7:0] qlost_next;
   logic [7:0] elost_next;
   logic qwin_done;
   logic ewin_done;
   logic restore;
   logic wr_mode;
   logic lat_valid;

   assign wr_mode = reg_req.wr && (reg_req.addr == rlqm_pkg::ADDR_MODE);
   assign restore = link_init_fail && mode_reg[rlqm_pkg::MODE_RESTORE];
   assign qwin_done = frame_end && (qframe_reg == 4'(rlqm_pkg::QUAL_FRAMES - 1));
   assign ewin_done = frame_end && (eframe_reg == 5'(rlqm_pkg::ERR_FRAMES - 1));
   assign lat_valid = (reg_req.wdata == rlqm_pkg::LAT_SHORT) ||
                      (reg_req.wdata == rlqm_pkg::LAT_NOMINAL) ||
                      (reg_req.wdata == rlqm_pkg::LAT_HIGH);

   // Lost count including a loss in the closing cycle, saturating at 255
   always_comb
   begin
      qlost_next = qlost_reg;
      elost_next = elost_reg;
      if (packet_lost && (qlost_reg != rlqm_pkg::COUNT_MAX))
      begin
         qlost_next = qlost_reg + 8'h01;
      end
      if (packet_lost && (elost_reg != rlqm_pkg::COUNT_MAX))
      begin
         elost_next = elost_reg + 8'h01;
      end
   end

   // ---------------------------------------------------------------
   // Host writable registers
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         mode_reg <= rlqm_pkg::MODE_RST;
      end
      else if (restore)
      begin
         mode_reg <= rlqm_pkg::MODE_RST;
      end
      else if (wr_mode)
      begin
         mode_reg <= reg_req.wdata & rlqm_pkg::MODE_WMASK;
      end
      else
      begin
         // Reconfigure request is a one-shot, the bit clears itself
         mode_reg[rlqm_pkg::MODE_RECONF] <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         warn_reg <= rlqm_pkg::WARN_RST;
      end
      else if (restore)
      begin
         warn_reg <= rlqm_pkg::WARN_RST;
      end
      else if (reg_req.wr && (reg_req.addr == rlqm_pkg::ADDR_WARN))
      begin
         warn_reg <= reg_req.wdata;
      end
   end

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         alarm_reg <= rlqm_pkg::ALARM_RST;
      end
      else if (restore)
      begin
         alarm_reg <= rlqm_pkg::ALARM_RST;
      end
      else if (reg_req.wr && (reg_req.addr == rlqm_pkg::ADDR_ALARM))
      begin
         alarm_reg <= reg_req.wdata;
      end
   end

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         latency_reg <= rlqm_pkg::LATENCY_RST;
      end
      else if (restore)
      begin
         latency_reg <= rlqm_pkg::LATENCY_RST;
      end
      else if (reg_req.wr && (reg_req.addr == rlqm_pkg::ADDR_LATENCY) && lat_valid)
      begin
         latency_reg <= reg_req.wdata;
      end
   end

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         irq_cfg_reg <= rlqm_pkg::IRQ_CFG_RST;
      end
      else if (restore)
      begin
         irq_cfg_reg <= rlqm_pkg::IRQ_CFG_RST;
      end
      else if (reg_req.wr && (reg_req.addr == rlqm_pkg::ADDR_IRQ_CFG))
      begin
         irq_cfg_reg <= reg_req.wdata;
      end
   end

   // ---------------------------------------------------------------
   // Frame windows and lost packet counts
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         qframe_reg <= 4'h0;
         qlost_reg <= 8'h00;
         quality_reg <= rlqm_pkg::QUALITY_RST;
      end
      else if (qwin_done)
      begin
         qframe_reg <= 4'h0;
         qlost_reg <= 8'h00;
         quality_reg <= rlqm_pkg::COUNT_MAX - qlost_next;
      end
      else
      begin
         if (frame_end)
         begin
            qframe_reg <= qframe_reg + 4'h1;
         end
         qlost_reg <= qlost_next;
      end
   end

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         eframe_reg <= 5'h00;
         elost_reg <= 8'h00;
         errors_reg <= rlqm_pkg::ERRORS_RST;
      end
      else if (ewin_done)
      begin
         eframe_reg <= 5'h00;
         elost_reg <= 8'h00;
         errors_reg <= elost_next;
      end
      else
      begin
         if (frame_end)
         begin
            eframe_reg <= eframe_reg + 5'h01;
         end
         elost_reg <= elost_next;
      end
   end

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         link_reg <= 1'b0;
      end
      else
      begin
         link_reg <= link_up;
      end
   end

   // ---------------------------------------------------------------
   // Threshold events and sticky flags
   // ---------------------------------------------------------------
   logic poor_event;
   logic err_event;
   logic [7:0] flag_clear;

   // Compare the freshly completed window value, not the stale register
   assign poor_event = IS_TX && qwin_done &&
                       ((rlqm_pkg::COUNT_MAX - qlost_next) <= warn_reg);
   assign err_event = ewin_done && (elost_next >= alarm_reg);
   assign flag_clear = (reg_req.wr && (reg_req.addr == rlqm_pkg::ADDR_IRQ_FLAGS)) ?
                       reg_req.wdata : 8'h00;

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         poor_flag_reg <= 1'b0;
      end
      else
      begin
         // A set in the same cycle as its clear wins
         poor_flag_reg <= poor_event ||
            (poor_flag_reg && !flag_clear[rlqm_pkg::FLAG_POOR]);
      end
   end

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         err_flag_reg <= 1'b0;
      end
      else
      begin
         // A set in the same cycle as its clear wins
         err_flag_reg <= err_event ||
            (err_flag_reg && !flag_clear[rlqm_pkg::FLAG_LINK_ERR]);
      end
   end

   // Unused flag positions read as zero
   always_comb
   begin
      flags_view = 8'h00;
      flags_view[rlqm_pkg::FLAG_POOR] = poor_flag_reg;
      flags_view[rlqm_pkg::FLAG_LINK_ERR] = err_flag_reg;
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   logic irq_active;
   logic [LAT_W-1:0] lat_smp;

   assign irq_active = |(flags_view & irq_cfg_reg & rlqm_pkg::FLAGS_MASK);

   always_comb
   begin
      case (latency_reg)
         rlqm_pkg::LAT_SHORT: lat_smp = LAT_W'(rlqm_pkg::LAT_SHORT_SMP);
         rlqm_pkg::LAT_HIGH: lat_smp = LAT_W'(rlqm_pkg::LAT_HIGH_SMP);
         default: lat_smp = LAT_W'(rlqm_pkg::LAT_NOMINAL_SMP);
      endcase
   end

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         irq_pin <= 1'b1;
         audio_mute <= 1'b0;
         afh_disable <= 1'b0;
         force_reconfig <= 1'b0;
         restore_defaults <= 1'b0;
         latency_samples <= LAT_W'(rlqm_pkg::LAT_NOMINAL_SMP);
      end
      else
      begin
         irq_pin <= irq_cfg_reg[rlqm_pkg::CFG_POLARITY] ? irq_active : !irq_active;
         audio_mute <= mode_reg[rlqm_pkg::MODE_MUTE] && (errors_reg > alarm_reg);
         afh_disable <= mode_reg[rlqm_pkg::MODE_NO_AFH];
         force_reconfig <= wr_mode && reg_req.wdata[rlqm_pkg::MODE_RECONF];
         restore_defaults <= restore;
         latency_samples <= lat_smp;
      end
   end

   // ---------------------------------------------------------------
   // Read port
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         reg_rdata <= 8'h00;
      end
      else if (reg_req.rd)
      begin
         case (reg_req.addr)
            rlqm_pkg::ADDR_IRQ_FLAGS: reg_rdata <= flags_view;
            rlqm_pkg::ADDR_LINK_STATE: reg_rdata <= {7'h00, IS_TX && link_reg};
            rlqm_pkg::ADDR_QUALITY: reg_rdata <= IS_TX ? quality_reg : 8'h00;
            rlqm_pkg::ADDR_ERRORS: reg_rdata <= errors_reg;
            rlqm_pkg::ADDR_MODE: reg_rdata <= mode_reg;
            rlqm_pkg::ADDR_WARN: reg_rdata <= warn_reg;
            rlqm_pkg::ADDR_ALARM: reg_rdata <= alarm_reg;
            rlqm_pkg::ADDR_LATENCY: reg_rdata <= latency_reg;
            rlqm_pkg::ADDR_IRQ_CFG: reg_rdata <= irq_cfg_reg;
            default: reg_rdata <= 8'h00;
         endcase
      end
   end

endmodule

//--- hw/rlqm_pkg.sv
package rlqm_pkg;

   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h02;
   localparam logic [7:0] ADDR_LINK_STATE = 8'h03;
   localparam logic [7:0] ADDR_QUALITY = 8'h04;
   localparam logic [7:0] ADDR_ERRORS = 8'h05;
   localparam logic [7:0] ADDR_MODE = 8'h36;
   localparam logic [7:0] ADDR_WARN = 8'h37;
   localparam logic [7:0] ADDR_ALARM = 8'h38;
   localparam logic [7:0] ADDR_LATENCY = 8'h52;
   localparam logic [7:0] ADDR_IRQ_CFG = 8'h53;

   // ---------------------------------------------------------------
   // Field positions and masks
   // ---------------------------------------------------------------
   localparam int FLAG_POOR = 5;
   localparam int FLAG_LINK_ERR = 2;
   localparam int CFG_POLARITY = 7;
   localparam int MODE_RESTORE = 6;
   localparam int MODE_RECONF = 4;
   localparam int MODE_MUTE = 3;
   localparam int MODE_NO_AFH = 2;
   localparam int STATE_LINK_UP = 0;
   localparam logic [7:0] MODE_WMASK = 8'h5f;
   localparam logic [7:0] FLAGS_MASK = 8'h24;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [7:0] WARN_RST = 8'h00;
   localparam logic [7:0] ALARM_RST = 8'hff;
   localparam logic [7:0] LATENCY_RST = 8'h02;
   localparam logic [7:0] IRQ_CFG_RST = 8'h00;
   localparam logic [7:0] QUALITY_RST = 8'hff;
   localparam logic [7:0] ERRORS_RST = 8'h00;

   // ---------------------------------------------------------------
   // Windows and counts
   // ---------------------------------------------------------------
   localparam int QUAL_FRAMES = 14;
   localparam int ERR_FRAMES = 32;
   localparam logic [7:0] COUNT_MAX = 8'hff;

   // ---------------------------------------------------------------
   // Latency settings
   // ---------------------------------------------------------------
   localparam logic [7:0] LAT_SHORT = 8'h00;
   localparam logic [7:0] LAT_NOMINAL = 8'h02;
   localparam logic [7:0] LAT_HIGH = 8'h04;
   localparam int SAMPLE_RATE_HZ = 48000;
   localparam int LAT_SHORT_US = 6000;
   localparam int LAT_NOMINAL_US = 11400;
   localparam int LAT_HIGH_US = 16700;
   localparam int LAT_SHORT_SMP = LAT_SHORT_US * SAMPLE_RATE_HZ / 1000000;
   localparam int LAT_NOMINAL_SMP = LAT_NOMINAL_US * SAMPLE_RATE_HZ / 1000000;
   localparam int LAT_HIGH_SMP = LAT_HIGH_US * SAMPLE_RATE_HZ / 1000000;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rlqm_reg_req_t;

endpackage

//--- test/rlqm_remote_model.sv
`timescale 1ns/1ps
// ---------------------------------------------
// Remote unit: lost packets, then frame end
// ---------------------------------------------
module rlqm_remote_model (
   input wire logic ref_clk,
   input wire logic send,
   input wire logic [1:0] n_lost,
   output logic frame_end,
   output logic packet_lost,
   output logic busy
);
   logic [2:0] left = 3'h0;
   initial
   begin
      frame_end = 1'b0;
      packet_lost = 1'b0;
      busy = 1'b0;
   end
   always @(negedge ref_clk)
   begin
      frame_end <= 1'b0;
      packet_lost <= 1'b0;
      if (send)
      begin
         left <= {1'b0, n_lost} + 3'h1;
         busy <= 1'b1;
      end
      else if (left > 3'h1)
      begin
         packet_lost <= 1'b1;
         left <= left - 3'h1;
      end
      else if (left == 3'h1)
      begin
         frame_end <= 1'b1;
         left <= 3'h0;
      end
      else
         busy <= 1'b0;
   end
endmodule

//--- test/rlqm_monitor_properties.sv
`timescale 1ns/1ps
module rlqm_monitor_properties #(
   parameter bit IS_TX = 1'b1,
   parameter int LAT_W = 10
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire rlqm_pkg::rlqm_reg_req_t reg_req,
   input wire logic [7:0] reg_rdata,
   input wire logic link_up,
   input wire logic link_init_fail,
   input wire logic afh_disable,
   input wire logic force_reconfig,
   input wire logic restore_defaults,
   input wire logic [LAT_W-1:0] latency_samples
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   logic wm;
   logic wl;
   logic ok;
   assign wm = reg_req.wr && reg_req.addr == rlqm_pkg::ADDR_MODE && !link_init_fail;
   assign wl = reg_req.wr && reg_req.addr == rlqm_pkg::ADDR_LATENCY && !link_init_fail;
   assign ok = reg_req.wdata inside {8'h00, 8'h02, 8'h04};
   function automatic logic [9:0] lat_of(input logic [7:0] v);
      return v == 8'h00 ? 10'h120 : v == 8'h02 ? 10'h223 : 10'h321;
   endfunction
   property p_afh;
      wm |-> ##2 afh_disable == $past(reg_req.wdata[2], 2);
   endproperty
   property p_rcf;
      wm && reg_req.wdata[4] |-> ##[1:2] force_reconfig;
   endproperty
   property p_rcf1;
      force_reconfig && !(reg_req.wr && reg_req.addr == rlqm_pkg::ADDR_MODE && reg_req.wdata[4])
         |=> !force_reconfig;
   endproperty
   property p_rst;
      restore_defaults |-> $past(link_init_fail) || $past(link_init_fail, 2);
   endproperty
   property p_rst_val;
      restore_defaults |-> ##[0:1] (latency_samples == 10'h223 && !afh_disable);
   endproperty
   property p_lat;
      wl && ok |-> ##2 latency_samples == lat_of($past(reg_req.wdata, 2));
   endproperty
   property p_lat_bad;
      wl && !ok |=> ##1 $stable(latency_samples);
   endproperty
   property p_hold;
      !reg_req.rd |=> $stable(reg_rdata);
   endproperty
   property p_unmap;
      reg_req.rd && reg_req.addr == 8'h00 |=> reg_rdata == 8'h00;
   endproperty
   property p_state;
      reg_req.rd && reg_req.addr == rlqm_pkg::ADDR_LINK_STATE && $stable(link_up)
         && link_up == $past(link_up, 2) |=> reg_rdata == {7'h00, IS_TX && $past(link_up)};
   endproperty
   a_afh: assert property (p_afh) else $error("afh disable wrong");
   a_rcf: assert property (p_rcf) else $error("no reconfig pulse");
   a_rcf1: assert property (p_rcf1) else $error("reconfig pulse too long");
   a_rst: assert property (p_rst) else $error("restore without init fail");
   a_rst_val: assert property (p_rst_val) else $error("restore values wrong");
   a_lat: assert property (p_lat) else $error("latency wrong");
   a_lat_bad: assert property (p_lat_bad) else $error("bad latency taken");
   a_hold: assert property (p_hold) else $error("read data moved");
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   a_state: assert property (p_state) else $error("link state wrong");
   c_rcf: cover property (force_reconfig);
   c_rst: cover property (restore_defaults);
   c_bad: cover property (wl && !ok);
endmodule
bind rlqm_monitor rlqm_monitor_properties #(.IS_TX(IS_TX), .LAT_W(LAT_W)) u_props (
   .ref_clk(ref_clk), .reset(reset), .reg_req(reg_req), .reg_rdata(reg_rdata),
   .link_up(link_up), .link_init_fail(link_init_fail), .afh_disable(afh_disable),
   .force_reconfig(force_reconfig), .restore_defaults(restore_defaults),
   .latency_samples(latency_samples));

//--- test/tb_radio_link_quality_monitor.sv
`timescale 1ns/1ps
`define CHK(g, e) check(16'(g), 16'(e))
module tb_radio_link_quality_monitor;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   rlqm_pkg::rlqm_reg_req_t reg_req = '0;
   logic link_up = 1'b0;
   logic link_init_fail = 1'b0;
   logic send = 1'b0;
   logic [1:0] n_lost = 2'h0;
   logic frame_end, packet_lost, busy, irq_pin, audio_mute;
   logic afh_disable, force_reconfig, restore_defaults;
   logic [7:0] reg_rdata;
   logic [7:0] rd_val;
   logic [9:0] latency_samples;
   int fails = 0;
   int n_tests = 0;
   int seed = 32'h3c3a;
   int q_lost = 0;
   int e_lost = 0;
   int n_rc = 0;
   int n_rs = 0;
   logic [7:0] exp_flags = 8'h00;
   localparam logic [7:0] WARN_LVL = 8'hfe;
   localparam logic [7:0] ALARM_LVL = 8'h05;
   logic [7:0] ra[10] = '{rlqm_pkg::ADDR_IRQ_FLAGS, rlqm_pkg::ADDR_LINK_STATE,
      rlqm_pkg::ADDR_QUALITY, rlqm_pkg::ADDR_ERRORS, rlqm_pkg::ADDR_MODE, rlqm_pkg::ADDR_WARN,
      rlqm_pkg::ADDR_ALARM, rlqm_pkg::ADDR_LATENCY, rlqm_pkg::ADDR_IRQ_CFG, 8'h00};
   logic [7:0] rv[10] = '{8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'hff, 8'h02, 8'h00, 8'h00};
   logic [7:0] lv[4] = '{8'h00, 8'h02, 8'h04, 8'h01};
   logic [9:0] le[4] = '{10'h120, 10'h223, 10'h321, 10'h321};
   always #2.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
   begin
      n_rc <= n_rc + int'(force_reconfig);
      n_rs <= n_rs + int'(restore_defaults);
   end
   rlqm_monitor dut (.ref_clk(ref_clk), .reset(reset), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .frame_end(frame_end), .packet_lost(packet_lost),
      .link_up(link_up), .link_init_fail(link_init_fail), .irq_pin(irq_pin),
      .audio_mute(audio_mute), .afh_disable(afh_disable), .force_reconfig(force_reconfig),
      .restore_defaults(restore_defaults), .latency_samples(latency_samples));
   rlqm_remote_model remote (.ref_clk(ref_clk), .send(send), .n_lost(n_lost),
      .frame_end(frame_end), .packet_lost(packet_lost), .busy(busy));
   // ---------------------------------------------
   // Bench tasks
   // ---------------------------------------------
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   function automatic logic [7:0] quality_of(input int lost);
      return rlqm_pkg::COUNT_MAX - 8'(lost);
   endfunction
   function automatic logic [7:0] errors_of(input int lost);
      return (lost > 255) ? 8'hff : 8'(lost);
   endfunction
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      reg_req <= '{1'b1, 1'b0, a, d};
      @(negedge ref_clk);
      reg_req <= '0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(negedge ref_clk);
      reg_req <= '{1'b0, 1'b1, a, 8'h00};
      @(negedge ref_clk);
      reg_req <= '0;
      @(negedge ref_clk);
      rd_val = reg_rdata;
   endtask
   task automatic frame(input logic [1:0] n);
      @(negedge ref_clk);
      send <= 1'b1;
      n_lost <= n;
      @(negedge ref_clk);
      send <= 1'b0;
      do @(posedge ref_clk); while (busy);
      q_lost += n;
      e_lost += n;
   endtask
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   initial
   begin
      #100000;
      fails++;
      wrap_up();
   end
   initial
   begin
      repeat (8) @(negedge ref_clk);
      reset <= 1'b0;
      `CHK(irq_pin, 1'b1);
      foreach (ra[i])
      begin
         rd(ra[i]);
         `CHK(rd_val, rv[i]);
      end
      $display("reset values done");
      wr(rlqm_pkg::ADDR_IRQ_CFG, 8'ha4);
      wr(rlqm_pkg::ADDR_WARN, WARN_LVL);
      wr(rlqm_pkg::ADDR_ALARM, ALARM_LVL);
      wr(rlqm_pkg::ADDR_MODE, 8'h08);
      link_up <= 1'b1;
      for (int i = 1; i <= 42; i++)
      begin
         frame(i == 1 ? 2'h2 : 2'($random(seed)));
         if (i % 14 == 0)
         begin
            repeat (3) @(negedge ref_clk);
            rd(rlqm_pkg::ADDR_QUALITY);
            `CHK(rd_val, quality_of(q_lost));
            if (quality_of(q_lost) <= WARN_LVL)
            begin
               exp_flags[rlqm_pkg::FLAG_POOR] = 1'b1;
            end
            q_lost = 0;
            rd(rlqm_pkg::ADDR_IRQ_FLAGS);
            `CHK(rd_val, exp_flags);
            `CHK(irq_pin, (i < 42) && (exp_flags != 8'h00));
         end
         if (i == 32)
         begin
            repeat (3) @(negedge ref_clk);
            rd(rlqm_pkg::ADDR_ERRORS);
            `CHK(rd_val, errors_of(e_lost));
            if (errors_of(e_lost) >= ALARM_LVL)
            begin
               exp_flags[rlqm_pkg::FLAG_LINK_ERR] = 1'b1;
            end
            rd(rlqm_pkg::ADDR_IRQ_FLAGS);
            `CHK(rd_val, exp_flags);
            `CHK(audio_mute, errors_of(e_lost) > ALARM_LVL);
            wr(rlqm_pkg::ADDR_IRQ_FLAGS, 8'h7f);
            exp_flags = 8'h00;
            repeat (2) @(negedge ref_clk);
            `CHK(irq_pin, 1'b0);
            wr(rlqm_pkg::ADDR_IRQ_CFG, 8'h80);
         end
      end
      wr(rlqm_pkg::ADDR_IRQ_CFG, 8'h20);
      repeat (2) @(negedge ref_clk);
      `CHK(irq_pin, !exp_flags[rlqm_pkg::FLAG_POOR]);
      $display("windows done");
      foreach (lv[i])
      begin
         wr(rlqm_pkg::ADDR_LATENCY, lv[i]);
         repeat (2) @(negedge ref_clk);
         `CHK(latency_samples, le[i]);
      end
      wr(rlqm_pkg::ADDR_MODE, 8'h54);
      repeat (2) @(negedge ref_clk);
      `CHK(n_rc, 1);
      `CHK(afh_disable, 1'b1);
      rd(rlqm_pkg::ADDR_MODE);
      `CHK(rd_val, 8'h44);
      link_init_fail <= 1'b1;
      @(negedge ref_clk);
      link_init_fail <= 1'b0;
      repeat (3) @(negedge ref_clk);
      `CHK(n_rs, 1);
      rd(rlqm_pkg::ADDR_ALARM);
      `CHK(rd_val, 8'hff);
      rd(rlqm_pkg::ADDR_LINK_STATE);
      `CHK(rd_val, 8'h01);
      $display("modes done");
      wrap_up();
   end
endmodule
